/* design/vpar_map.svh */
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes: definitions only
`ifndef VPAR_MAP_SVH
`define VPAR_MAP_SVH

// ****************************************
// register byte addresses
// ****************************************
`define VPAR_ADDR_CTRL 8'h00
`define VPAR_ADDR_SETTING 8'h04
`define VPAR_ADDR_CURRENT 8'h08
`define VPAR_ADDR_TUNE 8'h0C
`define VPAR_ADDR_STATUS 8'h10
`define VPAR_ADDR_AUTO 8'h14
`define VPAR_ADDR_STEP 8'h18

// ****************************************
// field positions
// ****************************************
`define VPAR_CTRL_AUTOSCALE 0
`define VPAR_CTRL_AUTOGRAD 1
`define VPAR_CTRL_BLANK_LO 2
`define VPAR_CTRL_FREQ_LO 4
`define VPAR_CTRL_FREEWHEEL 6
`define VPAR_CTRL_GAIN_LO 8
`define VPAR_SET_GRAD_LO 8
`define VPAR_CUR_HOLD_LO 8
`define VPAR_CUR_HOLD_SEL 16
`define VPAR_CUR_MSRES_LO 24
`define VPAR_TUNE_STANDSTILL 0
`define VPAR_TUNE_MOTION 1
`define VPAR_STAT_GRAD_LO 8
`define VPAR_STAT_SUM_LO 16
`define VPAR_STAT_SAT 24
`define VPAR_STAT_TUNED 25
`define VPAR_STAT_SMP_OK 26

// ****************************************
// reset values
// ****************************************
`define VPAR_RST_CTRL 32'h0000_0107
`define VPAR_RST_SETTING 32'h0000_0E24
`define VPAR_RST_CURRENT 32'h0800_101F
`define VPAR_RST_TUNE 32'h0000_0000

// ****************************************
// timing counts in clock cycles, and the sine peak
// ****************************************
`define VPAR_BLANK_00 10'h010
`define VPAR_BLANK_01 10'h018
`define VPAR_BLANK_10 10'h020
`define VPAR_BLANK_11 10'h028
`define VPAR_DPER_00 16'h0400
`define VPAR_DPER_01 16'h02AB
`define VPAR_DPER_10 16'h0200
`define VPAR_DPER_11 16'h019A
`define VPAR_SINE_PEAK 16'h00F8
`define VPAR_STEP_MAX 20'hF_FFFF

`endif

/* design/vpar_pkg.sv */
// Purpose: shared types of the amplitude regulator
// Assumes: constants live in vpar_map.svh
// Notes: none
package vpar_pkg;
	typedef logic [7:0] vpar_ampl_t;
	typedef logic signed [9:0] vpar_auto_t;
	typedef enum logic [1:0] {
		VPAR_MODE_FF = 2'b00,
		VPAR_MODE_AUTO_MGRAD = 2'b01,
		VPAR_MODE_AUTO = 2'b10
	} vpar_mode_t;
endpackage

/* design/vpar_chop_if.sv */
// Purpose: links the regulator to the chopper period timer
// Assumes: one clock
// Notes: none
`timescale 1ns/1ns
interface vpar_chop_if;
	logic [7:0] duty;
	logic [1:0] blank_sel;
	logic [1:0] freq_sel;
	logic on_phase;
	logic sample_strobe;
	logic period_end;
	logic [9:0] phase_cnt;
	modport ctrl (output duty, blank_sel, freq_sel,
		input on_phase, sample_strobe, period_end, phase_cnt);
	modport timer (input duty, blank_sel, freq_sel,
		output on_phase, sample_strobe, period_end, phase_cnt);
endinterface

/* design/vpar_chop_timer.sv */
// Purpose: chopper period, on-phase and post-blank sample strobe
// Assumes: duty is the current amplitude
// Notes: odd double periods round down to one whole chopper period
`timescale 1ns/1ns
`include "vpar_map.svh"
module vpar_chop_timer (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// regulator side
	vpar_chop_if.timer ch
);
	logic [9:0] cnt_r;
	logic [9:0] half;
	logic [9:0] blank;
	logic [9:0] on_len;

	always_comb begin
		unique case (ch.freq_sel)
			2'b00: half = 10'(`VPAR_DPER_00 >> 1);
			2'b01: half = 10'(`VPAR_DPER_01 >> 1);
			2'b10: half = 10'(`VPAR_DPER_10 >> 1);
			2'b11: half = 10'(`VPAR_DPER_11 >> 1);
		endcase
		unique case (ch.blank_sel)
			2'b00: blank = `VPAR_BLANK_00;
			2'b01: blank = `VPAR_BLANK_01; // [RULE5]
			2'b10: blank = `VPAR_BLANK_10;
			2'b11: blank = `VPAR_BLANK_11;
		endcase
	end

	// on-phase length follows the amplitude
	assign on_len = 10'((18'(half) * 18'(ch.duty)) >> 8);
	// a frequency change mid-period just wraps early
	assign ch.period_end = (cnt_r >= half - 10'h001); // [RULE5]
	assign ch.on_phase = (cnt_r < on_len);
	// current seen only after blanking, inside the on-phase
	assign ch.sample_strobe = ch.on_phase && (cnt_r == blank); // [RULE4]
	assign ch.phase_cnt = cnt_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 10'h000;
		end else if (ch.period_end) begin
			cnt_r <= 10'h000;
		end else begin
			cnt_r <= cnt_r + 10'h001;
		end
	end
endmodule // vpar_chop_timer

/* design/vpar_step_meter.sv */
// Purpose: clocks between step edges, scaled to 256 microsteps
// Assumes: step pin is asynchronous
// Notes: saturates at the maximum in standstill
`timescale 1ns/1ns
`include "vpar_map.svh"
module vpar_step_meter (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pin and setting
	input wire logic step_pin,
	input wire logic [3:0] msres,
	// result
	output logic [19:0] step_interval_count
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic [19:0] cnt_r;
	logic [3:0] shift;
	logic edge_seen;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= step_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign edge_seen = s2_r && !s3_r;
	// fewer microsteps means longer gaps: shrink to 256 equivalent
	assign shift = (msres > 4'h8) ? 4'h0 : 4'h8 - msres; // [RULE13]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 20'h0_0001;
			step_interval_count <= `VPAR_STEP_MAX;
		end else if (edge_seen) begin
			cnt_r <= 20'h0_0001;
			step_interval_count <= (cnt_r == `VPAR_STEP_MAX) ?
				`VPAR_STEP_MAX : (cnt_r >> shift); // [RULE13]
		end else if (cnt_r != `VPAR_STEP_MAX) begin
			cnt_r <= cnt_r + 20'h0_0001;
		end else begin
			step_interval_count <= `VPAR_STEP_MAX;
		end
	end
endmodule // vpar_step_meter

/* design/vpar_top.sv */
// Purpose: amplitude regulator for a voltage-mode PWM chopper
// Assumes: AHB-Lite register access, sampled coil current on a pin bus
// Notes: zero-wait slave, always OKAY
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "vpar_map.svh"

// What this block does
// RULE1 - both auto bits: regulate current via auto term
// RULE2 - gain field sets the proportional step
// RULE3 - motion tuning: regulator absorbs velocity changes
// RULE4 - sample current in on-phase after blanking
// RULE5 - blank 01 is 24 cycles, freq 00 1024/2
// RULE6 - reduced currents scale learned or programmed base
// RULE7 - zero amplitude only with freewheeling
// RULE8 - software keeps standstill-tuning current above limit
// RULE9 - software keeps run scale within 8..31
// RULE10 - after tuning, low run/hold currents still work
// RULE11 - autoscale off: pure feed-forward, no loop
// RULE12 - sum is offset plus gradient*256*fstep/fclk
// RULE13 - step rate normalized to 256 microsteps
// RULE14 - 8-bit amplitude scales 248-peak sine
// RULE15 - learned offset and gradient readable
// RULE16 - auto regulation keeps running after tuning
// RULE17 - sum saturates at 255, flagged
// RULE18 - one regulator update per chopper period
module vpar_top (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// motor side pins
	input wire logic step_pin,
	input wire logic [7:0] coil_current,
	// chopper drive
	output logic [7:0] pwm_amplitude,
	output logic [7:0] drive_peak,
	output logic chopper_on,
	output logic freewheel_active
);
	vpar_chop_if ch ();

	// ****************************************
	// registers and bus slave
	// ****************************************
	logic [31:0] ctrl_r;
	logic [31:0] setting_r;
	logic [31:0] current_r;
	logic [31:0] tune_r;
	logic wr_pend_r;
	logic [7:0] wa_r;
	logic [31:0] hrdata_r;
	logic [31:0] rd_mux;
	logic addr_ok;
	logic [19:0] step_interval_count;
	logic [7:0] learned_amplitude_offset;
	logic [7:0] learned_amplitude_gradient;
	vpar_pkg::vpar_ampl_t effective_amplitude_sum;
	vpar_pkg::vpar_auto_t auto_r;
	logic sat_r;
	logic tuned_r;
	logic ss_done_r;
	logic smp_vld_r;
	logic [7:0] smp_r;
	logic [7:0] cur1_r;
	logic [7:0] cur2_r;
	logic [7:0] peak_r;

	assign addr_ok = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr)
			`VPAR_ADDR_CTRL: rd_mux = ctrl_r;
			`VPAR_ADDR_SETTING: rd_mux = setting_r;
			`VPAR_ADDR_CURRENT: rd_mux = current_r;
			`VPAR_ADDR_TUNE: rd_mux = tune_r;
			`VPAR_ADDR_STATUS: begin
				rd_mux[7:0] = learned_amplitude_offset; // [RULE15]
				rd_mux[`VPAR_STAT_GRAD_LO +: 8] =
					learned_amplitude_gradient; // [RULE15]
				rd_mux[`VPAR_STAT_SUM_LO +: 8] = effective_amplitude_sum;
				rd_mux[`VPAR_STAT_SAT] = sat_r; // [RULE17]
				rd_mux[`VPAR_STAT_TUNED] = tuned_r;
				rd_mux[`VPAR_STAT_SMP_OK] = smp_vld_r;
			end
			`VPAR_ADDR_AUTO: rd_mux = 32'(auto_r);
			`VPAR_ADDR_STEP: rd_mux = {12'h000, step_interval_count};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data is captured in the address phase, shown in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wa_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else begin
			wr_pend_r <= addr_ok && hwrite;
			if (addr_ok) begin
				wa_r <= haddr;
			end
			if (addr_ok && !hwrite) begin
				hrdata_r <= rd_mux;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= `VPAR_RST_CTRL;
			setting_r <= `VPAR_RST_SETTING;
			current_r <= `VPAR_RST_CURRENT;
			tune_r <= `VPAR_RST_TUNE;
		end else if (wr_pend_r) begin
			unique case (wa_r)
				`VPAR_ADDR_CTRL: ctrl_r <= {20'h0_0000, hwdata[11:8],
					1'b0, hwdata[6:0]};
				`VPAR_ADDR_SETTING: setting_r <= {16'h0000, hwdata[15:0]};
				`VPAR_ADDR_CURRENT: current_r <= {4'h0, hwdata[27:24],
					7'h00, hwdata[16], 3'h0, hwdata[12:8], 3'h0,
					hwdata[4:0]};
				`VPAR_ADDR_TUNE: tune_r <= {30'h0000_0000, hwdata[1:0]};
				default: ;
			endcase
		end
	end

	// ****************************************
	// control decode
	// ****************************************
	logic autoscale;
	logic autograd;
	logic fw_en;
	logic [3:0] gain;
	logic [7:0] amplitude_offset_setting;
	logic [7:0] amplitude_gradient_setting;
	logic [4:0] run_current_scale;
	logic [4:0] hold_current_scale;
	logic [4:0] cs;
	logic standstill_tuning_phase;
	logic motion_tuning_phase;
	logic [7:0] target;
	vpar_pkg::vpar_mode_t mode;

	assign autoscale = ctrl_r[`VPAR_CTRL_AUTOSCALE];
	assign autograd = ctrl_r[`VPAR_CTRL_AUTOGRAD];
	assign fw_en = ctrl_r[`VPAR_CTRL_FREEWHEEL];
	assign gain = ctrl_r[`VPAR_CTRL_GAIN_LO +: 4]; // [RULE2]
	assign amplitude_offset_setting = setting_r[7:0];
	assign amplitude_gradient_setting = setting_r[`VPAR_SET_GRAD_LO +: 8];
	assign run_current_scale = current_r[4:0];
	assign hold_current_scale = current_r[`VPAR_CUR_HOLD_LO +: 5];
	assign cs = current_r[`VPAR_CUR_HOLD_SEL] ? hold_current_scale :
		run_current_scale;
	assign standstill_tuning_phase = tune_r[`VPAR_TUNE_STANDSTILL];
	assign motion_tuning_phase = tune_r[`VPAR_TUNE_MOTION];
	// target current as (cs+1)*8-1 on the sample scale
	assign target = {cs, 3'b111};
	assign mode = !autoscale ? vpar_pkg::VPAR_MODE_FF :
		autograd ? vpar_pkg::VPAR_MODE_AUTO :
		vpar_pkg::VPAR_MODE_AUTO_MGRAD;

	// ****************************************
	// current sampling
	// ****************************************
	assign ch.duty = effective_amplitude_sum;
	assign ch.blank_sel = ctrl_r[`VPAR_CTRL_BLANK_LO +: 2];
	assign ch.freq_sel = ctrl_r[`VPAR_CTRL_FREQ_LO +: 2];

	vpar_chop_timer u_chop (
		.hclk(hclk),
		.hresetn(hresetn),
		.ch(ch)
	);

	vpar_step_meter u_step (
		.hclk(hclk),
		.hresetn(hresetn),
		.step_pin(step_pin),
		.msres(current_r[`VPAR_CUR_MSRES_LO +: 4]),
		.step_interval_count(step_interval_count)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur1_r <= 8'h00;
			cur2_r <= 8'h00;
		end else begin
			cur1_r <= coil_current;
			cur2_r <= cur1_r;
		end
	end

	// a short on-phase never reaches the strobe: no sample, no update
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			smp_r <= 8'h00;
			smp_vld_r <= 1'b0;
		end else if (ch.sample_strobe) begin
			smp_r <= cur2_r; // [RULE4]
			smp_vld_r <= 1'b1;
		end else if (ch.period_end) begin
			smp_vld_r <= 1'b0;
		end
	end

	// ****************************************
	// proportional regulator
	// ****************************************
	logic signed [8:0] err;
	logic signed [13:0] prod;
	logic signed [13:0] delta;
	logic signed [10:0] auto_sum;
	logic signed [10:0] ofs_sum;
	logic upd;

	assign err = $signed({1'b0, target}) - $signed({1'b0, smp_r});
	assign prod = 14'(err * $signed({1'b0, gain})); // [RULE2]
	assign delta = prod >>> 4;
	assign auto_sum = 11'(auto_r) + 11'(delta);
	assign ofs_sum = $signed({3'b000, learned_amplitude_offset}) +
		11'(delta);
	// runs whenever autoscale is set, tuned or not
	assign upd = autoscale && ch.period_end && smp_vld_r; // [RULE1] [RULE16] [RULE18]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			auto_r <= 10'sh000;
		end else if (upd && !standstill_tuning_phase) begin
			if (auto_sum > 11'sh1FF) begin
				auto_r <= 10'sh1FF;
			end else if (auto_sum < -11'sh200) begin
				auto_r <= -10'sh200;
			end else begin
				auto_r <= 10'(auto_sum); // [RULE1] [RULE3]
			end
		end
	end

	// standstill tuning folds the error into the learned offset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			learned_amplitude_offset <= 8'h00;
		end else if (wr_pend_r && wa_r == `VPAR_ADDR_TUNE &&
			!standstill_tuning_phase &&
			hwdata[`VPAR_TUNE_STANDSTILL]) begin
			// seed from the programmed offset: a near-zero start never
			// opens the on-phase past blanking, so nothing gets sampled
			learned_amplitude_offset <= amplitude_offset_setting; // [RULE1]
		end else if (upd && standstill_tuning_phase) begin
			if (ofs_sum > 11'sh0FF) begin
				learned_amplitude_offset <= 8'hFF;
			end else if (ofs_sum < 11'sh000) begin
				learned_amplitude_offset <= 8'h00;
			end else begin
				learned_amplitude_offset <= 8'(ofs_sum);
			end
		end
	end

	// motion tuning pulls the gradient after the auto term
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			learned_amplitude_gradient <= 8'h00;
		end else if (upd && motion_tuning_phase && autograd) begin
			if (auto_r > 10'sh000 && learned_amplitude_gradient != 8'hFF) begin
				learned_amplitude_gradient <=
					learned_amplitude_gradient + 8'h01; // [RULE3]
			end else if (auto_r < 10'sh000 &&
				learned_amplitude_gradient != 8'h00) begin
				learned_amplitude_gradient <=
					learned_amplitude_gradient - 8'h01; // [RULE3]
			end
		end
	end

	// tuned once standstill ran and motion tuning is then left
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ss_done_r <= 1'b0;
			tuned_r <= 1'b0;
		end else begin
			if (standstill_tuning_phase) begin
				ss_done_r <= 1'b1;
			end
			if (ss_done_r && wr_pend_r && wa_r == `VPAR_ADDR_TUNE &&
				motion_tuning_phase && !hwdata[`VPAR_TUNE_MOTION]) begin
				tuned_r <= 1'b1; // [RULE10]
			end
		end
	end

	// ****************************************
	// amplitude sum
	// ****************************************
	logic [7:0] base_ofs;
	logic [7:0] base_grad;
	logic [15:0] vel;
	logic [8:0] vel_c;
	logic [14:0] scaled;
	logic signed [11:0] raw;
	logic fw_zero;
	logic [7:0] sum_nxt;
	logic sat_nxt;

	assign base_ofs = autoscale ? learned_amplitude_offset :
		amplitude_offset_setting; // [RULE6]
	assign base_grad = (mode == vpar_pkg::VPAR_MODE_AUTO) ?
		learned_amplitude_gradient : amplitude_gradient_setting; // [RULE6]
	// grad*256*fstep/fclk with fstep/fclk = 1/interval
	assign vel = (step_interval_count == 20'h0_0000) ? 16'h0000 :
		16'(({base_grad, 8'h00}) / step_interval_count); // [RULE12]
	assign vel_c = (vel > 16'h00FF) ? 9'h0FF : vel[8:0];
	// reduced currents scale the base by (cs+1)/32
	assign scaled = 15'((10'(base_ofs) + 10'(vel_c)) * (15'(cs) +
		15'h0001)) >> 5; // [RULE6] [RULE10] [RULE12]
	assign raw = $signed({2'b00, scaled[9:0]}) +
		(autoscale ? 12'(auto_r) : 12'sh000); // [RULE11]
	assign fw_zero = fw_en && (cs == 5'h00);

	always_comb begin
		sat_nxt = 1'b0;
		if (fw_zero) begin
			sum_nxt = 8'h00; // [RULE7]
		end else if (raw >= 12'sh0FF) begin
			sum_nxt = 8'hFF; // [RULE17]
			sat_nxt = 1'b1;
		end else if (raw < 12'sh001) begin
			sum_nxt = 8'h01; // [RULE7]
		end else begin
			sum_nxt = 8'(raw); // [RULE14]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			effective_amplitude_sum <= 8'h00;
			sat_r <= 1'b0;
			peak_r <= 8'h00;
		end else begin
			effective_amplitude_sum <= sum_nxt;
			sat_r <= sat_nxt;
			peak_r <= 8'((16'(sum_nxt) * `VPAR_SINE_PEAK) >> 8); // [RULE14]
		end
	end

	assign pwm_amplitude = effective_amplitude_sum;
	assign drive_peak = peak_r;
	assign chopper_on = ch.on_phase;
	assign freewheel_active = fw_zero;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_ff_no_loop;
		!autoscale |=> $stable(auto_r);
	endproperty
	a_ff_no_loop: assert property (p_ff_no_loop) else $error("auto moved in ff mode"); // [RULE11]

	property p_upd_period;
		$changed(auto_r) |-> $past(ch.period_end) && $past(smp_vld_r);
	endproperty
	a_upd_period: assert property (p_upd_period) else $error("auto moved off period"); // [RULE18]

	property p_gain_zero;
		upd && gain == 4'h0 |=> $stable(auto_r);
	endproperty
	a_gain_zero: assert property (p_gain_zero) else $error("zero gain moved auto"); // [RULE2]

	property p_regulate_up;
		upd && !standstill_tuning_phase && gain == 4'hF &&
			smp_r == 8'h00 && target == 8'hFF && auto_r < 10'sh000
			|=> auto_r > $past(auto_r);
	endproperty
	a_regulate_up: assert property (p_regulate_up) else $error("no rise on low current"); // [RULE1]

	property p_sample_on;
		ch.sample_strobe |-> ch.on_phase &&
			ch.phase_cnt >= `VPAR_BLANK_00;
	endproperty
	a_sample_on: assert property (p_sample_on) else $error("sample outside window"); // [RULE4]

	property p_blank24;
		ch.sample_strobe && ch.blank_sel == 2'b01 |-> ch.phase_cnt == 10'd24;
	endproperty
	a_blank24: assert property (p_blank24) else $error("blank not 24"); // [RULE5]

	property p_zero_fw;
		pwm_amplitude == 8'h00 && $past(hresetn) |-> $past(fw_zero);
	endproperty
	a_zero_fw: assert property (p_zero_fw) else $error("zero without freewheel"); // [RULE7]

	property p_sat;
		sat_r |-> pwm_amplitude == 8'hFF;
	endproperty
	a_sat: assert property (p_sat) else $error("sat flag without 255"); // [RULE17]

	property p_ff_idle;
		!autoscale && step_interval_count == 20'hF_FFFF && cs == 5'h1F &&
			amplitude_offset_setting != 8'h00 && !fw_zero
			|=> pwm_amplitude == $past(amplitude_offset_setting);
	endproperty
	a_ff_idle: assert property (p_ff_idle) else $error("ff sum not offset"); // [RULE12]

	c_sample: cover property (ch.sample_strobe);
	c_sat: cover property ($rose(sat_r));
	c_tuned: cover property ($rose(tuned_r));
endmodule // vpar_top

/* dv/vpar_motor_model.sv */
// Purpose: coil and shunt model, plus a step pulse source
// Assumes: sensed current follows the amplitude only in on-phase
// Notes: half doubles the coil resistance
`timescale 1ns/1ns
module vpar_motor_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// regulator drive
	input wire logic [7:0] pwm_amplitude,
	input wire logic chopper_on,
	// test controls
	input wire logic half,
	input wire logic [15:0] step_period,
	// sense and step
	output logic [7:0] coil_current,
	output logic step_pin
);
	logic [15:0] step_cnt;
	// ****************************************
	// shunt
	// ****************************************
	// off-phase shunt shows junk, so a late sample is caught
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			coil_current <= 8'h00;
		else if (chopper_on)
			coil_current <= half ? {1'b0, pwm_amplitude[7:1]} : pwm_amplitude;
		else
			coil_current <= ~coil_current;
	end
	// ****************************************
	// step source
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn || step_period == 16'h0000) begin
			step_cnt <= 16'h0000;
			step_pin <= 1'b0;
		end else begin
			step_cnt <= (step_cnt >= step_period - 16'h0001) ? 16'h0000 : step_cnt + 16'h0001;
			step_pin <= step_cnt < 16'h0004;
		end
	end
endmodule // vpar_motor_model

/* dv/testbench.sv */
// Purpose: register-level tests of the amplitude regulator
// Assumes: zero-wait slave, hready fed back from hreadyout
// Notes: auto scenarios need tens of chopper periods
`timescale 1ns/1ns
`include "vpar_map.svh"
module testbench;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, step_pin;
	logic [7:0] haddr, coil_current, pwm_amplitude, drive_peak;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic chopper_on, freewheel_active, half;
	logic [15:0] step_period;
	int err_count, compares, n;
	assign hready = hreadyout;
	vpar_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .step_pin(step_pin),
		.coil_current(coil_current), .pwm_amplitude(pwm_amplitude),
		.drive_peak(drive_peak), .chopper_on(chopper_on),
		.freewheel_active(freewheel_active));
	vpar_motor_model i_motor (.hclk(hclk), .hresetn(hresetn),
		.pwm_amplitude(pwm_amplitude), .chopper_on(chopper_on),
		.half(half), .step_period(step_period),
		.coil_current(coil_current), .step_pin(step_pin));
	// ****************************************
	// bus and check tasks
	// ****************************************
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		// launch right after an edge, whatever the caller waited on
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic rng(input logic [31:0] lo, hi, g);
		compares++;
		if (((g >= lo) && (g <= hi)) !== 1'b1) begin
			err_count++;
			$display("wrong value at %0t: range %h..%h got %h", $time, lo, hi, g);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0000_0000);
		chk(e, rd);
	endtask
	// sampling lands after the edge's updates
	task automatic tick(input int k);
		repeat (k) @(posedge hclk);
		#1;
	endtask
	task automatic give_verdict;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ****************************************
	// clock, watchdog, tests
	// ****************************************
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	initial begin
		#300000;
		err_count++;
		give_verdict();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		half = 1'b0;
		step_period = 16'h0000;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(`VPAR_ADDR_CTRL, 32'h0000_0107);
		rdchk(`VPAR_ADDR_SETTING, 32'h0000_0E24);
		rdchk(`VPAR_ADDR_CURRENT, 32'h0800_101F);
		rdchk(`VPAR_ADDR_TUNE, 32'h0000_0000);
		ahb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		rdchk(8'h1C, 32'h0000_0000);
		// feed-forward: offset only at standstill, plus velocity term when stepping
		ahb(1'b1, `VPAR_ADDR_CTRL, 32'h0000_0104);
		ahb(1'b1, `VPAR_ADDR_SETTING, 32'h0000_1040);
		tick(4);
		chk(32'h0000_0040, pwm_amplitude);
		chk(32'h0000_003E, drive_peak);
		step_period <= 16'h0080;
		tick(512);
		rdchk(`VPAR_ADDR_STEP, 32'h0000_0080);
		chk(32'h0000_0060, pwm_amplitude);
		// 16 microsteps at 16x the interval: same 256-equivalent rate
		ahb(1'b1, `VPAR_ADDR_CURRENT, 32'h0400_001F);
		step_period <= 16'h0800;
		tick(6200);
		rdchk(`VPAR_ADDR_STEP, 32'h0000_0080);
		chk(32'h0000_0060, pwm_amplitude);
		ahb(1'b1, `VPAR_ADDR_SETTING, 32'h0000_FFFF);
		tick(4);
		chk(32'h0000_00FF, pwm_amplitude);
		ahb(1'b0, `VPAR_ADDR_STATUS, 32'h0000_0000);
		chk({8'hFF, 1'b1}, {rd[23:16], rd[24]});
		// reduced currents from the programmed base
		ahb(1'b1, `VPAR_ADDR_SETTING, 32'h0000_0040);
		ahb(1'b1, `VPAR_ADDR_CURRENT, 32'h0801_0F1F);
		tick(4);
		chk(32'h0000_0020, pwm_amplitude);
		ahb(1'b1, `VPAR_ADDR_CURRENT, 32'h0801_001F);
		tick(4);
		chk({8'h02, 1'b0}, {pwm_amplitude, freewheel_active});
		ahb(1'b1, `VPAR_ADDR_CTRL, 32'h0000_0144);
		tick(4);
		chk({8'h00, 1'b1}, {pwm_amplitude, freewheel_active});
		// automatic mode, standstill tuning, run scale 15
		ahb(1'b1, `VPAR_ADDR_CURRENT, 32'h0800_000F);
		ahb(1'b1, `VPAR_ADDR_CTRL, 32'h0000_0407);
		ahb(1'b1, `VPAR_ADDR_TUNE, 32'h0000_0001);
		tick(20480);
		rng(32'h0000_0077, 32'h0000_0087, pwm_amplitude);
		n = 0;
		while (chopper_on !== 1'b0) tick(1);
		while (chopper_on !== 1'b1) tick(1);
		while (chopper_on === 1'b1) begin tick(1); n++; end
		while (chopper_on !== 1'b1) begin tick(1); n++; end
		chk(32'd512, n);
		// coil resistance doubles in motion tuning: gradient follows
		half <= 1'b1;
		ahb(1'b1, `VPAR_ADDR_TUNE, 32'h0000_0002);
		tick(10240);
		ahb(1'b1, `VPAR_ADDR_TUNE, 32'h0000_0000);
		ahb(1'b0, `VPAR_ADDR_STATUS, 32'h0000_0000);
		chk(32'h0000_0001, rd[25]);
		rng(32'h0000_0001, 32'h0000_00FF, rd[7:0]);
		rng(32'h0000_0001, 32'h0000_00FF, rd[15:8]);
		// regulation keeps tracking after tuning
		tick(20480);
		rng(32'h0000_00F0, 32'h0000_00FF, pwm_amplitude);
		rdchk(`VPAR_ADDR_CTRL, 32'h0000_0407);
		ahb(1'b0, `VPAR_ADDR_AUTO, 32'h0000_0000);
		rng(32'h0000_0001, 32'h0000_01FF, rd);
		// back to feed-forward: auto term no longer counts
		ahb(1'b1, `VPAR_ADDR_CTRL, 32'h0000_0104);
		tick(4);
		chk(32'h0000_0020, pwm_amplitude);
		give_verdict();
	end
endmodule // testbench
